// file: rtwt_map.svh
// Constants for the two-wire clock-chip target port and its master.
// Assumes both ends run on clk_sys at 10 MHz and share the bus by open drain.
`ifndef RTWT_MAP_SVH
`define RTWT_MAP_SVH
`define RTWT_DEV_ADDR     7'h51
`define RTWT_DIR_READ     1'b1
`define RTWT_TEST_LOC_A   8'h49
`define RTWT_TEST_LOC_B   8'h4a
`define RTWT_PTR_RESET    8'h00
`define RTWT_CLK_HZ       10000000
`define RTWT_SCL_NS       2000
`define RTWT_HALF_CYC     ((`RTWT_SCL_NS * (`RTWT_CLK_HZ / 1000000)) / 2000)
`define RTWT_BIT_MSB      3'h7
`define RTWT_ACK_SLOT     4'h8
`endif

// file: rtwt_pkg.sv
// Types shared by both ends of the two-wire target port.
// Assumes rtwt_map.svh supplies the numeric constants.
package rtwt_pkg;
  typedef logic [7:0] rtwt_byte_t;
  typedef logic [6:0] rtwt_addr_t;
  typedef enum logic [2:0] {
    RTWT_T_IDLE = 3'b000,
    RTWT_T_ADDR = 3'b001,
    RTWT_T_PTR  = 3'b010,
    RTWT_T_WDAT = 3'b011,
    RTWT_T_RDAT = 3'b100,
    RTWT_T_WAIT = 3'b101
  } rtwt_tgt_e;
  typedef enum logic [2:0] {
    RTWT_M_IDLE  = 3'b000,
    RTWT_M_START = 3'b001,
    RTWT_M_BIT   = 3'b010,
    RTWT_M_STOP  = 3'b011,
    RTWT_M_DONE  = 3'b100
  } rtwt_mst_e;
endpackage

// file: rtwt_if.sv
// Two-wire bus between the clock-chip target and its master.
// Assumes external pull-ups: a released line reads high.
`timescale 1ns/1ps
`default_nettype none
interface rtwt_if;
  logic scl_m_oe;
  logic sda_m_oe;
  logic scl_t_oe;
  logic sda_t_oe;
  logic scl_o;
  logic sda_o;
  logic scl_line;
  logic sda_line;
  // Wired-AND: any enabled driver pulls low, since outputs only drive zero.
  assign scl_line = ~((scl_m_oe & ~scl_o) | scl_t_oe);
  assign sda_line = ~((sda_m_oe & ~sda_o) | sda_t_oe);
  modport master (input scl_line, input sda_line, output scl_m_oe, output sda_m_oe,
                  output scl_o, output sda_o);
  modport target (input scl_line, input sda_line, output scl_t_oe, output sda_t_oe);
endinterface
`default_nettype wire

// file: rtwt_target.sv
// Clock-chip two-wire target port: decodes conditions, address, pointer and data.
// Assumes the bus lines arrive asynchronously; clk_sys oversamples them.
// The register space itself lives outside and answers rd_data combinationally.
`timescale 1ns/1ps
`default_nettype none
`include "rtwt_map.svh"
module rtwt_target (
  input  wire logic          clk_sys,  // System clock.
  input  wire logic          rst_n,    // Asynchronous reset, active low.
  rtwt_if.target             bus,      // Two-wire bus.
  output var  rtwt_pkg::rtwt_byte_t ptr,      // Register pointer.
  output var  rtwt_pkg::rtwt_byte_t wr_data,  // Byte written.
  output var  logic          wr_stb,   // Write strobe, one cycle.
  input  wire rtwt_pkg::rtwt_byte_t rd_data,  // Byte at pointer.
  output var  logic          busy      // In a transaction from start; dropped on stop, when not addressed, or when the master does not acknowledge a read byte.
);
  import rtwt_pkg::*;
  // ==========================================================================
  // Line synchronisers and condition detection
  logic [1:0] scl_sy_ff, sda_sy_ff;
  logic       scl_d_ff, sda_d_ff;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_sy_ff <= 2'h3;
      sda_sy_ff <= 2'h3;
      scl_d_ff  <= 1'b1;
      sda_d_ff  <= 1'b1;
    end else begin
      scl_sy_ff <= {scl_sy_ff[0], bus.scl_line};
      sda_sy_ff <= {sda_sy_ff[0], bus.sda_line};
      scl_d_ff  <= scl_sy_ff[1];
      sda_d_ff  <= sda_sy_ff[1];
    end
  end
  wire scl_s    = scl_sy_ff[1];
  wire sda_s    = sda_sy_ff[1];
  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  // Data moving while clock is high is a condition, never a bit.
  wire start_c  = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire stop_c   = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  // ==========================================================================
  // Byte engine
  rtwt_tgt_e  st_ff;
  logic [3:0] bit_ff;
  rtwt_byte_t sh_ff, ptr_ff, wd_ff, tx_ff;
  logic       sda_oe_ff, wstb_ff, mnack_ff, ack_ff;
  wire        byte_in  = scl_rise & (bit_ff == 4'h7);
  wire        [7:0] rx = {sh_ff[6:0], sda_s};
  wire        addr_hit = (rx[7:1] == `RTWT_DEV_ADDR);
  wire        rd_dir   = (rx[0] == `RTWT_DIR_READ);
  wire        rx_state = (st_ff == RTWT_T_ADDR) | (st_ff == RTWT_T_PTR) | (st_ff == RTWT_T_WDAT);
  wire        tx_state = (st_ff == RTWT_T_RDAT);
  // Bit counter: 0..7 data bits, 8 waits for the clock fall, 9 is the acknowledge slot.
  wire        slot_beg = scl_fall & (bit_ff == 4'h8);
  wire        slot_end = scl_fall & (bit_ff == 4'h9);
  wire        tx_bit   = scl_fall & tx_state & (bit_ff != 4'h0) & (bit_ff < 4'h8);
  wire        tx_next  = tx_state & (ack_ff | ~mnack_ff);
  wire        own_ack  = (st_ff != RTWT_T_ADDR) | addr_hit;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= RTWT_T_IDLE;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      ptr_ff <= `RTWT_PTR_RESET;
      wd_ff <= 8'h00;
      tx_ff <= 8'h00;
      sda_oe_ff <= 1'b0;
      wstb_ff <= 1'b0;
      mnack_ff <= 1'b0;
      ack_ff <= 1'b0;
    end else begin
      wstb_ff <= 1'b0;
      if (start_c) begin
        st_ff <= RTWT_T_ADDR;
        bit_ff <= 4'h0;
        sda_oe_ff <= 1'b0;
        ack_ff <= 1'b0;
      end else if (stop_c) begin
        st_ff <= RTWT_T_IDLE;
        sda_oe_ff <= 1'b0;
        ack_ff <= 1'b0;
      end else if (st_ff == RTWT_T_IDLE || st_ff == RTWT_T_WAIT) begin
        sda_oe_ff <= 1'b0;
      end else begin
        if (scl_rise && bit_ff < 4'h8) begin
          sh_ff <= rx;
          bit_ff <= bit_ff + 4'h1;
        end
        if (scl_rise && bit_ff == 4'h9 && !ack_ff) begin
          mnack_ff <= sda_s;
        end
        if (byte_in && rx_state) begin
          ack_ff <= own_ack;
          case (st_ff)
            RTWT_T_ADDR: begin
              if (!addr_hit) begin
                st_ff <= RTWT_T_WAIT;
              end else if (rd_dir) begin
                st_ff <= RTWT_T_RDAT;
              end else begin
                st_ff <= RTWT_T_PTR;
              end
            end
            RTWT_T_PTR: begin
              ptr_ff <= rx;
              st_ff <= RTWT_T_WDAT;
            end
            RTWT_T_WDAT: begin
              wd_ff <= rx;
              wstb_ff <= 1'b1;
            end
            default: begin
              st_ff <= st_ff;
            end
          endcase
        end
        if (slot_beg) begin
          // Transmitter lets go, receiver pulls low for the acknowledge.
          bit_ff <= 4'h9;
          sda_oe_ff <= ack_ff;
          if (tx_state && !ack_ff) begin
            ptr_ff <= ptr_ff + 8'h01;
          end
        end
        if (slot_end) begin
          bit_ff <= 4'h0;
          ack_ff <= 1'b0;
          if (tx_next) begin
            tx_ff <= {rd_data[6:0], 1'b0};
            sda_oe_ff <= ~rd_data[7];
          end else if (tx_state) begin
            st_ff <= RTWT_T_WAIT;
            sda_oe_ff <= 1'b0;
          end else begin
            sda_oe_ff <= 1'b0;
          end
        end
        if (tx_bit) begin
          sda_oe_ff <= ~tx_ff[7];
          tx_ff <= {tx_ff[6:0], 1'b0};
        end
        if (wstb_ff) begin
          ptr_ff <= ptr_ff + 8'h01;
        end
      end
    end
  end
  // Busy lags the state by one cycle so that it comes from a flip-flop.
  logic busy_ff;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (st_ff != RTWT_T_IDLE) && (st_ff != RTWT_T_WAIT);
    end
  end
  assign bus.scl_t_oe = 1'b0;
  assign bus.sda_t_oe = sda_oe_ff;
  assign ptr     = ptr_ff;
  assign wr_data = wd_ff;
  assign wr_stb  = wstb_ff;
  assign busy    = busy_ff;
endmodule
`default_nettype wire

// file: rtwt_master.sv
// Two-wire master end: runs one write or read transaction per request.
// Assumes it alone drives the clock; clock period is a divider of clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "rtwt_map.svh"
module rtwt_master (
  input  wire logic          clk_sys,  // System clock.
  input  wire logic          rst_n,    // Asynchronous reset, active low.
  rtwt_if.master             bus,      // Two-wire bus.
  input  wire logic          go,       // Start a transaction, one cycle.
  input  wire logic          rd,       // 1 read, 0 write.
  input  wire logic          set_ptr,  // Write: send pointer byte first.
  input  wire rtwt_pkg::rtwt_byte_t ptr_in,   // Pointer value to load.
  input  wire rtwt_pkg::rtwt_byte_t wdat,     // Write data byte.
  input  wire logic [3:0]    nbytes,   // Data bytes, at least one.
  output var  rtwt_pkg::rtwt_byte_t rdat,     // Last byte read.
  output var  logic          rd_vld,   // Read byte valid, one cycle.
  output var  logic          nack,     // Target missed an acknowledge.
  output var  logic          done      // Transaction over, one cycle.
);
  import rtwt_pkg::*;
  // ==========================================================================
  // Sequencer: each bus bit takes four quarter phases of the divided clock.
  rtwt_mst_e  st_ff;
  logic [7:0] cnt_ff;
  logic [1:0] ph_ff;
  logic [3:0] bit_ff, left_ff;
  logic [1:0] stage_ff;  // 0 address, 1 pointer, 2 data.
  rtwt_byte_t sh_ff, rd_ff;
  logic       scl_ff, sda_ff, rv_ff, nk_ff, dn_ff, rd_ff_dir;
  logic [1:0] sda_sy_ff;
  wire        tick = (cnt_ff == 8'h00);
  wire        sda_s = sda_sy_ff[1];
  wire        rx_mode = rd_ff_dir && stage_ff == 2'h2;
  wire        last = (left_ff == 4'h1);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sda_sy_ff <= 2'h3;
    end else begin
      sda_sy_ff <= {sda_sy_ff[0], bus.sda_line};
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= RTWT_M_IDLE; cnt_ff <= 8'h00; ph_ff <= 2'h0; bit_ff <= 4'h0;
      left_ff <= 4'h0; stage_ff <= 2'h0; sh_ff <= 8'h00; rd_ff <= 8'h00;
      scl_ff <= 1'b1; sda_ff <= 1'b1; rv_ff <= 1'b0; nk_ff <= 1'b0;
      dn_ff <= 1'b0; rd_ff_dir <= 1'b0;
    end else begin
      rv_ff <= 1'b0;
      dn_ff <= 1'b0;
      cnt_ff <= tick ? 8'((`RTWT_HALF_CYC / 2) - 1) : cnt_ff - 8'h01;
      case (st_ff)
        RTWT_M_IDLE: begin
          if (go) begin
            st_ff <= RTWT_M_START; ph_ff <= 2'h0; nk_ff <= 1'b0;
            rd_ff_dir <= rd; left_ff <= nbytes;
            sh_ff <= {`RTWT_DEV_ADDR, rd};
            stage_ff <= (rd || !set_ptr) ? 2'h2 : 2'h1;
            if (!rd && set_ptr) stage_ff <= 2'h0;
            if (!rd) stage_ff <= 2'h0;
            if (rd) stage_ff <= 2'h0;
          end
        end
        RTWT_M_START: if (tick) begin
          ph_ff <= ph_ff + 2'h1;
          if (ph_ff == 2'h1) sda_ff <= 1'b0;
          if (ph_ff == 2'h3) begin
            scl_ff <= 1'b0; st_ff <= RTWT_M_BIT; bit_ff <= 4'h0; ph_ff <= 2'h0;
          end
        end
        RTWT_M_BIT: if (tick) begin
          ph_ff <= ph_ff + 2'h1;
          case (ph_ff)
            2'h0: begin  // Clock low: change data only here.
              if (bit_ff < 4'h8) sda_ff <= rx_mode ? 1'b1 : sh_ff[7];
              else sda_ff <= rx_mode ? last : 1'b1;
            end
            2'h1: scl_ff <= 1'b1;
            2'h2: begin
              if (bit_ff < 4'h8) sh_ff <= {sh_ff[6:0], sda_s};
              else if (!rx_mode && sda_s) nk_ff <= 1'b1;
            end
            default: begin
              scl_ff <= 1'b0;
              bit_ff <= bit_ff + 4'h1;
              if (bit_ff == 4'h8) begin
                bit_ff <= 4'h0;
                if (rx_mode) begin rd_ff <= sh_ff; rv_ff <= 1'b1; end
                if (stage_ff == 2'h0) begin
                  stage_ff <= (!rd_ff_dir && set_ptr) ? 2'h1 : 2'h2;
                  sh_ff <= (!rd_ff_dir && set_ptr) ? ptr_in : wdat;
                end else if (stage_ff == 2'h1) begin
                  stage_ff <= 2'h2; sh_ff <= wdat;
                end else begin
                  left_ff <= left_ff - 4'h1; sh_ff <= wdat;
                  if (last) st_ff <= RTWT_M_STOP;
                end
                if (sda_s && !rx_mode) st_ff <= RTWT_M_STOP;
              end
            end
          endcase
        end
        RTWT_M_STOP: if (tick) begin
          ph_ff <= ph_ff + 2'h1;
          if (ph_ff == 2'h0) sda_ff <= 1'b0;
          if (ph_ff == 2'h1) scl_ff <= 1'b1;
          if (ph_ff == 2'h3) begin sda_ff <= 1'b1; st_ff <= RTWT_M_DONE; end
        end
        default: begin dn_ff <= 1'b1; st_ff <= RTWT_M_IDLE; end
      endcase
    end
  end
  assign bus.scl_o    = 1'b0;
  assign bus.sda_o    = 1'b0;
  assign bus.scl_m_oe = ~scl_ff;
  assign bus.sda_m_oe = ~sda_ff;
  assign rdat   = rd_ff;
  assign rd_vld = rv_ff;
  assign nack   = nk_ff;
  assign done   = dn_ff;
endmodule
`default_nettype wire

// file: rtwt_bus_sva.sv
// Checker for the two-wire bus that joins the target and master ends.
// Assumes the bench instantiates it beside the interface and feeds the raw lines.
`timescale 1ns/1ps
`default_nettype none
`include "rtwt_map.svh"
module rtwt_bus_sva (
  input wire logic clk_sys,   // System clock.
  input wire logic rst_n,     // Asynchronous reset, active low.
  input wire logic scl_m_oe,  // Master pulls clock low.
  input wire logic sda_m_oe,  // Master pulls data low.
  input wire logic scl_t_oe,  // Target pulls clock low.
  input wire logic sda_t_oe,  // Target pulls data low.
  input wire logic scl_o,     // Master clock level when enabled.
  input wire logic sda_o,     // Master data level when enabled.
  input wire logic scl_line,  // Resolved clock line.
  input wire logic sda_line   // Resolved data line.
);
  // ==========================================================
  // Line tracking
  // ==========================================================
  logic       scl_ff;
  logic       sda_ff;
  logic       idle_ff;
  logic       first_ff;
  logic [3:0] bcnt_ff;
  logic [7:0] sh_ff;
  wire start_w = scl_ff & scl_line & sda_ff & ~sda_line;
  wire stop_w  = scl_ff & scl_line & ~sda_ff & sda_line;
  wire rise_w  = scl_line & ~scl_ff;
  wire fall_w  = ~scl_line & scl_ff;
  wire addr_ok = (sh_ff[7:1] == `RTWT_DEV_ADDR);
  wire wr_dir  = addr_ok & ~sh_ff[0];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      idle_ff <= 1'b1;
      first_ff <= 1'b0;
      bcnt_ff <= 4'h0;
      sh_ff <= 8'h00;
    end else begin
      scl_ff <= scl_line;
      sda_ff <= sda_line;
      idle_ff <= start_w ? 1'b0 : (stop_w ? 1'b1 : idle_ff);
      first_ff <= start_w | (first_ff & ~(fall_w & (bcnt_ff == 4'h9)));
      bcnt_ff <= start_w ? 4'h0 : ((first_ff & rise_w) ? bcnt_ff + 4'h1 : bcnt_ff);
      if (first_ff && rise_w && bcnt_ff < 4'h8) begin
        sh_ff <= {sh_ff[6:0], sda_line};
      end
    end
  end
  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_pull_low_only: assert property (!scl_o && !sda_o && !scl_t_oe)
    else $error("bus driven high or target drives clock");
  a_tgt_change_low: assert property ($changed(sda_t_oe) |-> !scl_line)
    else $error("target changed data while clock high");
  a_start_clocks: assert property (start_w |-> ##[1:40] !scl_line)
    else $error("no clock after start");
  a_stop_released: assert property (stop_w |=> (!sda_t_oe && sda_line) [*4])
    else $error("bus not released after stop");
  a_idle_quiet: assert property (idle_ff |-> !sda_t_oe && !scl_m_oe)
    else $error("bus driven outside a transaction");
  a_addr_no_drive: assert property (first_ff && bcnt_ff < 4'h8 |-> !sda_t_oe)
    else $error("target drove data during address");
  a_addr_ack: assert property (first_ff && addr_ok && bcnt_ff == 4'h9 && scl_line |-> sda_t_oe)
    else $error("own address not acknowledged");
  a_ack_release: assert property (first_ff && wr_dir && bcnt_ff == 4'h9 && fall_w |-> ##[1:8] !sda_t_oe)
    else $error("acknowledge not released");
  a_scl_low_bound: assert property ($fell(scl_line) |-> ##[1:60] scl_line)
    else $error("clock held low too long");
endmodule
`default_nettype wire

// file: tb_top.sv
// Testbench joining both ends of the two-wire port through the interface.
// Assumes the target's register space is modelled here by a fixed pattern.
`timescale 1ns/1ps
`default_nettype none
`include "rtwt_map.svh"
module tb_top;
  import rtwt_pkg::*;
  logic            clk_sys, rst_n, go, rd, set_ptr, wr_stb, busy, rd_vld, nack, done;
  rtwt_byte_t      ptr_in, wdat, ptr, wr_data, rd_data, rdat;
  logic [3:0]      nbytes;
  int              err_total, n_compared, cyc;
  rtwt_byte_t      wq[$], rq[$];
  logic            mscl_ff, msda_ff, mfirst_ff, mack_ff;
  logic [3:0]      mbits_ff;
  rtwt_byte_t      msh_ff, maddr_ff;
  rtwt_if bus();
  rtwt_target u_rtwt_target (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .ptr(ptr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_data(rd_data), .busy(busy));
  rtwt_master u_rtwt_master (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .go(go), .rd(rd),
    .set_ptr(set_ptr), .ptr_in(ptr_in), .wdat(wdat), .nbytes(nbytes), .rdat(rdat),
    .rd_vld(rd_vld), .nack(nack), .done(done));
  rtwt_bus_sva u_rtwt_bus_sva (.clk_sys(clk_sys), .rst_n(rst_n), .scl_m_oe(bus.scl_m_oe),
    .sda_m_oe(bus.sda_m_oe), .scl_t_oe(bus.scl_t_oe), .sda_t_oe(bus.sda_t_oe),
    .scl_o(bus.scl_o), .sda_o(bus.sda_o), .scl_line(bus.scl_line), .sda_line(bus.sda_line));
  // Each register reads as its own index folded with a mask, so pointer slips show.
  assign rd_data = ptr ^ 8'h3c;
  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;
  // ==========================================================
  // Collectors, wire monitor and timeout
  // ==========================================================
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (wr_stb === 1'b1) wq.push_back(wr_data);
    if (rd_vld === 1'b1) rq.push_back(rdat);
    if (cyc >= 30000) begin
      err_total = err_total + 1;
      report_and_stop();
    end
  end
  // Captures the first byte after each start and the acknowledge bit that follows it.
  always @(posedge clk_sys) begin
    mscl_ff <= bus.scl_line;
    msda_ff <= bus.sda_line;
    if (mscl_ff && bus.scl_line && msda_ff && !bus.sda_line) begin
      mfirst_ff <= 1'b1;
      mbits_ff <= 4'h0;
    end else if (mfirst_ff && !mscl_ff && bus.scl_line) begin
      mbits_ff <= mbits_ff + 4'h1;
      if (mbits_ff < 4'h8) msh_ff <= {msh_ff[6:0], bus.sda_line};
      else begin
        maddr_ff <= msh_ff;
        mack_ff <= bus.sda_line;
        mfirst_ff <= 1'b0;
      end
    end
  end
  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic report_and_stop();
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input rtwt_byte_t got, input rtwt_byte_t exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One whole transaction; go is only raised when the master is idle.
  task automatic xfer(input logic r, input logic sp, input rtwt_byte_t p, input rtwt_byte_t w,
                      input logic [3:0] n, input rtwt_byte_t exp_ptr);
    int k;
    wq.delete();
    rq.delete();
    @(posedge clk_sys);
    go <= 1'b1;
    rd <= r;
    set_ptr <= sp;
    ptr_in <= p;
    wdat <= w;
    nbytes <= n;
    @(posedge clk_sys);
    go <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 8000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 8000) begin
      err_total++;
      $display("BAD %0t no done", $time);
    end
    // The target sees the stop through two synchroniser stages before busy drops.
    repeat (8) @(posedge clk_sys);
    chk(ptr, exp_ptr, "pointer");
    chk(maddr_ff, {`RTWT_DEV_ADDR, r}, "address byte");
    chk({7'h00, mack_ff}, 8'h00, "address ack");
    chk({6'h00, nack, busy}, 8'h00, "nack busy");
    chk({6'h00, bus.scl_line, bus.sda_line}, 8'h03, "idle lines");
  endtask
  task automatic chk_w(input rtwt_byte_t w, input int n);
    chk(8'(wq.size()), 8'(n), "write count");
    chk(8'(rq.size()), 8'h00, "stray reads");
    foreach (wq[i]) chk(wq[i], w, "write data");
  endtask
  task automatic chk_r(input rtwt_byte_t p, input int n);
    chk(8'(rq.size()), 8'(n), "read count");
    chk(8'(wq.size()), 8'h00, "stray writes");
    foreach (rq[i]) chk(rq[i], (p + 8'(i)) ^ 8'h3c, "read data");
  endtask
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    rst_n = 1'b0;
    go = 1'b0;
    rd = 1'b0;
    set_ptr = 1'b0;
    ptr_in = 8'h00;
    wdat = 8'h00;
    nbytes = 4'h1;
    err_total = 0;
    n_compared = 0;
    cyc = 0;
    mfirst_ff = 1'b0;
    mbits_ff = 4'h0;
    msh_ff = 8'h00;
    maddr_ff = 8'h00;
    mack_ff = 1'b1;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk(ptr, `RTWT_PTR_RESET, "reset pointer");
    xfer(1'b0, 1'b1, 8'h10, 8'hc5, 4'h3, 8'h13);
    chk_w(8'hc5, 3);
    xfer(1'b1, 1'b0, 8'h00, 8'h00, 4'h2, 8'h15);
    chk_r(8'h13, 2);
    xfer(1'b0, 1'b1, 8'hfe, 8'h3a, 4'h4, 8'h02);
    chk_w(8'h3a, 4);
    // The long burst stays clear of the two factory test locations.
    xfer(1'b0, 1'b1, 8'h20, 8'h81, 4'hf, 8'h2f);
    chk_w(8'h81, 15);
    xfer(1'b1, 1'b0, 8'h00, 8'h00, 4'h3, 8'h32);
    chk_r(8'h2f, 3);
    report_and_stop();
  end
endmodule
`default_nettype wire
